/* File: logic/reset_source_controller.sv */
// reset source controller: cause flags, soft reset, release sequencing
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps

// Summary of operation
// - pin low past minimum width is synchronised, filtered, then resets
// - pin reset sets the pin reset flag, bit 7
// - software reset takes the same release path as a pin reset
// - arm bit writes ignored unless the unlock sequence completed
// - writing one to bit 0 arms a pending software reset
// - reading the armed register triggers reset on the next cycle
// - software reset sets the soft reset flag, bit 6
// - watchdog timeout while running is synchronised then resets
// - watchdog timeout in sleep or idle wakes to reset vector only
// - brown-out is synchronised, resets, and sets flag bit 1
// - each config load compares bit pairs; mismatch raises a reset
// - mismatch reset sets the config mismatch flag, bit 9
// - resets load the reset vector; interrupt wake loads the vector given
// - power-on sets bits 0 and 1; brown-out keeps only power-on
// - wait instruction sets sleep or idle flag; pin/watchdog keep it
// - flags are software settable and clearable and survive other resets
// - every reset reloads config; only power-on presets words to ones
// - boot clock comes from the boot oscillator select field of each reload without a mismatch
// - pin, mismatch, soft, watchdog: reload time plus eight cycles only
// - power-on adds power-up delay; power-on and brown-out add clock delays
// - clear, set, invert companions act on ones bits; reads return zero
// - core reset released eight cycles after system reset release
module reset_source_controller #(
   parameter int POWERUP_CYCLES = rstc_pkg::POWERUP_CYC
) (
   // clock and power-on reset
   input  wire logic               i_clk_sys,
   input  wire logic               i_rst_n,
   // register bus
   input  wire rstc_pkg::avmm_req_s i_avmm,
   output logic [31:0]             o_avmm_readdata,
   output logic                    o_avmm_waitrequest,
   // reset sources, asynchronous
   input  wire logic               i_ext_reset_pin_n,
   input  wire logic               i_watchdog_timeout,
   input  wire logic               i_brownout,
   // power modes
   input  wire logic               i_wait_sleep,
   input  wire logic               i_wait_idle,
   input  wire logic               i_int_wake,
   input  wire logic [31:0]        i_int_vector,
   // configuration words and complements
   input  wire logic [31:0]        i_cfg_word,
   input  wire logic [31:0]        i_cfg_comp,
   input  wire logic               i_cfg_load_sleep,
   // reset outputs
   output logic                    o_internal_system_reset,
   output logic                    o_core_reset,
   output logic                    o_cfg_preset,
   output logic                    o_cfg_reload,
   output logic [2:0]              o_boot_osc_select,
   output logic [31:0]             o_restart_pc,
   output logic                    o_wake_to_reset_vector
);
   import rstc_pkg::*;

   logic [2:0]       sync1;
   logic [2:0]       sync2;
   logic             wdt_last;
   logic [3:0]       pin_cnt;
   logic             pin_req;
   logic             bor_req;
   logic             wdt_ev;
   logic             wdt_run;
   logic             swr_req;
   logic             cmr_req;
   logic             any_req;
   logic             lowpwr;
   logic             mismatch;
   logic             reload_end;
   logic [9:0]       flags;
   logic [9:0]       next_flags;
   logic             arm;
   logic [1:0]       unlock;
   logic             need_osc;
   logic [2:0]       boot_osc;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] osc_cycles;
   seq_state_e       state;
   logic             acc_wr;
   logic             acc_rd;
   logic [31:0]      wd;

   // two-stage synchronisers for pin, watchdog and brown-out
   genvar g;
   for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
         if (!i_rst_n) begin
            sync1[g] <= 1'b0;
            sync2[g] <= 1'b0;
         end else begin
            sync1[g] <= (g == 0) ? !i_ext_reset_pin_n
                      : (g == 1) ? i_watchdog_timeout : i_brownout;
            sync2[g] <= sync1[g];
         end
      end
   end

   // noise filter: pin must stay low the minimum width
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_cnt  <= 4'h0;
         wdt_last <= 1'b0;
      end else begin
         wdt_last <= sync2[1];
         if (!sync2[0])
            pin_cnt <= 4'h0;
         else if (pin_cnt != 4'(PIN_MIN_CYC))
            pin_cnt <= pin_cnt + 4'h1;
      end
   end

   assign pin_req = pin_cnt == 4'(PIN_MIN_CYC);
   assign bor_req = sync2[2];
   assign wdt_ev  = sync2[1] && !wdt_last;
   assign wdt_run = wdt_ev && !lowpwr;
   assign mismatch   = (i_cfg_word ^ i_cfg_comp) != 32'hFFFF_FFFF;
   assign reload_end = state == ST_RELOAD
                    && cnt == CNT_W'(RELOAD_CYC - 1);
   assign cmr_req = mismatch && (reload_end || i_cfg_load_sleep);
   // software reset takes the same path as a pin reset
   assign any_req = pin_req || bor_req || wdt_run || swr_req
                 || cmr_req;

   // bus access is taken on the edge where waitrequest is low
   assign acc_wr = i_avmm.write && !o_avmm_waitrequest;
   assign acc_rd = i_avmm.read && !o_avmm_waitrequest;
   assign wd     = i_avmm.writedata;

   // one wait state per access keeps read data registered
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_avmm_waitrequest <= 1'b1;
         o_avmm_readdata    <= 32'h0000_0000;
      end else begin
         o_avmm_waitrequest <= !((i_avmm.read || i_avmm.write)
                                 && o_avmm_waitrequest);
         if (i_avmm.read && o_avmm_waitrequest) begin
            unique case (i_avmm.address)
               OFS_CAUSE:  o_avmm_readdata <= {22'h0, flags};
               OFS_SWR:    o_avmm_readdata <= {31'h0, arm};
               OFS_STATUS: o_avmm_readdata <= {25'h0, unlock[1],
                                               need_osc, boot_osc,
                                               lowpwr, o_core_reset};
               // companions and unmapped offsets read zero
               default:    o_avmm_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // unlock sequence: key one then key two, any other value relocks
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         unlock <= 2'h0;
      else if (any_req)
         unlock <= 2'h0;
      else if (acc_wr && i_avmm.address == OFS_UNLOCK) begin
         if (wd == UNLOCK_KEY1)
            unlock <= 2'h1;
         else if (wd == UNLOCK_KEY2 && unlock == 2'h1)
            unlock <= 2'h2;
         else
            unlock <= 2'h0;
      end
   end

   // arm bit, written only while unlocked; read while armed triggers
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         arm     <= 1'b0;
         swr_req <= 1'b0;
      end else begin
         swr_req <= acc_rd && i_avmm.address == OFS_SWR && arm;
         if (any_req)
            arm <= 1'b0;
         else if (acc_wr && unlock[1]) begin
            unique case (i_avmm.address)
               OFS_SWR:     arm <= wd[0];
               OFS_SWR_SET: arm <= arm || wd[0];
               OFS_SWR_CLR: arm <= arm && !wd[0];
               OFS_SWR_INV: arm <= arm ^ wd[0];
               default:     arm <= arm;
            endcase
         end
      end
   end

   // sleep or idle entered by the wait instruction
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         lowpwr <= 1'b0;
      else if (any_req || i_int_wake || wdt_ev)
         lowpwr <= 1'b0;
      else if (i_wait_sleep || i_wait_idle)
         lowpwr <= 1'b1;
   end

   // cause flags: software op first, then brown-out clear, then sets
   always_comb begin
      next_flags = flags;
      if (acc_wr) begin
         unique case (i_avmm.address)
            OFS_CAUSE:     next_flags = wd[9:0];
            OFS_CAUSE_CLR: next_flags = flags & ~wd[9:0];
            OFS_CAUSE_SET: next_flags = flags | wd[9:0];
            OFS_CAUSE_INV: next_flags = flags ^ wd[9:0];
            default:       next_flags = flags;
         endcase
      end
      if (bor_req)
         next_flags = next_flags & (10'h001 << F_POR);
      // hardware sets win over a clear in the same cycle
      next_flags[F_BOR]   = next_flags[F_BOR] || bor_req;
      next_flags[F_PIN_RESET_FLAG]  = next_flags[F_PIN_RESET_FLAG] || pin_req;
      next_flags[F_SWR]   = next_flags[F_SWR] || swr_req;
      next_flags[F_WATCHDOG_TIMEOUT_FLAG]  = next_flags[F_WATCHDOG_TIMEOUT_FLAG] || wdt_ev;
      next_flags[F_CMR]   = next_flags[F_CMR] || cmr_req;
      next_flags[F_SLEEP] = next_flags[F_SLEEP] || i_wait_sleep;
      next_flags[F_IDLE]  = next_flags[F_IDLE] || i_wait_idle;
      next_flags = next_flags & FLAG_MASK;
   end

   // power-on reset is the async reset of this block itself
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         flags <= FLAG_RST;
      else
         flags <= next_flags;
   end

   // clock delays depend on the boot oscillator: pll and crystal codes
   always_comb begin
      osc_cycles = CNT_W'(FSCM_CYC);
      if (boot_osc == 3'h1 || boot_osc == 3'h3)
         osc_cycles = osc_cycles + CNT_W'(LOCK_CYC);
      if (boot_osc == 3'h2 || boot_osc == 3'h3 || boot_osc == 3'h4)
         osc_cycles = osc_cycles + CNT_W'(OST_CYC);
      if (boot_osc == 3'h0 || boot_osc == 3'h7)
         osc_cycles = CNT_W'(1);
   end

   // release sequence; a held source keeps the reload restarting
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state    <= ST_POWERUP;
         cnt      <= '0;
         need_osc <= 1'b1;
      end else if (any_req) begin
         state    <= ST_RELOAD;
         cnt      <= '0;
         need_osc <= need_osc || bor_req;
      end else begin
         cnt <= cnt + CNT_W'(1);
         unique case (state)
            ST_POWERUP:
               if (cnt == CNT_W'(POWERUP_CYCLES - 1)) begin
                  state <= ST_PRESET;
                  cnt   <= '0;
               end
            ST_PRESET: begin
               state <= ST_RELOAD;
               cnt   <= '0;
            end
            ST_RELOAD:
               if (reload_end) begin
                  state <= need_osc ? ST_OSC : ST_SYSDLY;
                  cnt   <= '0;
               end
            ST_OSC:
               if (cnt == osc_cycles - CNT_W'(1)) begin
                  state <= ST_SYSDLY;
                  cnt   <= '0;
               end
            ST_SYSDLY:
               if (cnt == CNT_W'(SYSDLY_CYC - 1)) begin
                  state    <= ST_RUN;
                  need_osc <= 1'b0;
                  cnt      <= '0;
               end
            ST_RUN:
               cnt <= '0;
         endcase
      end
   end

   // boot clock latched from the config word at every reload without a mismatch
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         boot_osc <= BOOT_OSC_RST;
      else if (reload_end && !mismatch)
         boot_osc <= i_cfg_word[BOOT_OSC_LSB +: 3];
   end

   // registered reset and sequencing outputs
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_internal_system_reset <= 1'b1;
         o_core_reset            <= 1'b1;
         o_cfg_preset            <= 1'b0;
         o_cfg_reload            <= 1'b0;
         o_boot_osc_select       <= BOOT_OSC_RST;
      end else begin
         o_internal_system_reset <= any_req
            || !(state == ST_SYSDLY || state == ST_RUN);
         o_core_reset      <= any_req || state != ST_RUN;
         o_cfg_preset      <= state == ST_PRESET;
         o_cfg_reload      <= state == ST_RELOAD && !any_req;
         o_boot_osc_select <= boot_osc;
      end
   end

   // restart address and watchdog wake from low power
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_restart_pc           <= RESET_VECTOR;
         o_wake_to_reset_vector <= 1'b0;
      end else begin
         o_wake_to_reset_vector <= wdt_ev && lowpwr && !any_req;
         if (any_req || (wdt_ev && lowpwr))
            o_restart_pc <= RESET_VECTOR;
         else if (i_int_wake)
            o_restart_pc <= i_int_vector;
      end
   end

   // checks
   sequence trig_read_s;
      acc_rd && i_avmm.address == OFS_SWR && arm;
   endsequence
   sequence rel_s;
      $fell(o_internal_system_reset);
   endsequence

   pin_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(pin_req) |-> $past(sync2[0], PIN_MIN_CYC) ##1 o_internal_system_reset)
      else $error("pin reset not asserted");
   ext_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      pin_req |=> flags[F_PIN_RESET_FLAG])
      else $error("pin flag not set");
   arm_lock_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !unlock[1] && !arm |=> !arm)
      else $error("arm written while locked");
   soft_trig_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      trig_read_s |=> swr_req ##1 (o_internal_system_reset && flags[F_SWR]))
      else $error("soft reset not triggered");
   wdt_wake_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      wdt_ev && lowpwr && !any_req |=> o_wake_to_reset_vector
         && $stable(o_internal_system_reset) && o_restart_pc == RESET_VECTOR)
      else $error("watchdog wake wrong");
   bor_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      bor_req |=> flags[F_BOR] && !flags[F_PIN_RESET_FLAG] && o_internal_system_reset)
      else $error("brown-out flags wrong");
   cmr_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      cmr_req |=> flags[F_CMR] && state == ST_RELOAD)
      else $error("mismatch not handled");
   core_delay_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      rel_s |-> o_core_reset[*8] ##1 (!o_core_reset || o_internal_system_reset))
      else $error("core release timing wrong");
   reset_pc_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      any_req |=> o_restart_pc == RESET_VECTOR)
      else $error("restart address wrong");
   reload_time_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      swr_req && !need_osc ##1 !any_req [*8] |-> ##[8:30] !o_internal_system_reset)
      else $error("reload delay too long");
endmodule

/* File: logic/rstc_pkg.sv */
// constants, types and register map of the reset source controller
package rstc_pkg;
   // clock and times
   localparam int CLK_HZ        = 40_000_000;
   localparam int CLK_NS        = 25;
   localparam int POWERUP_MS    = 64;
   localparam int POWERUP_CYC   = POWERUP_MS * (CLK_HZ / 1000);
   localparam int PIN_MIN_NS    = 200;
   localparam int PIN_MIN_CYC   = (PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RELOAD_CYC    = 16;
   localparam int SYSDLY_CYC    = 8;
   localparam int OST_CYC       = 64;
   localparam int LOCK_CYC      = 32;
   localparam int FSCM_CYC      = 16;
   localparam int CNT_W         = 22;
   // register byte offsets
   localparam logic [5:0] OFS_CAUSE     = 6'h00;
   localparam logic [5:0] OFS_CAUSE_CLR = 6'h04;
   localparam logic [5:0] OFS_CAUSE_SET = 6'h08;
   localparam logic [5:0] OFS_CAUSE_INV = 6'h0C;
   localparam logic [5:0] OFS_SWR       = 6'h10;
   localparam logic [5:0] OFS_SWR_CLR   = 6'h14;
   localparam logic [5:0] OFS_SWR_SET   = 6'h18;
   localparam logic [5:0] OFS_SWR_INV   = 6'h1C;
   localparam logic [5:0] OFS_UNLOCK    = 6'h20;
   localparam logic [5:0] OFS_STATUS    = 6'h24;
   // unlock keys, values arbitrary
   localparam logic [31:0] UNLOCK_KEY1  = 32'h0000_A5C3;
   localparam logic [31:0] UNLOCK_KEY2  = 32'h0000_3C5A;
   // cause flag positions
   localparam int F_POR   = 0;
   localparam int F_BOR   = 1;
   localparam int F_IDLE  = 2;
   localparam int F_SLEEP = 3;
   localparam int F_WATCHDOG_TIMEOUT_FLAG  = 4;
   localparam int F_SWR   = 6;
   localparam int F_PIN_RESET_FLAG  = 7;
   localparam int F_CMR   = 9;
   localparam logic [9:0] FLAG_MASK   = 10'h2DF;
   localparam logic [9:0] FLAG_RST    = 10'h003;
   localparam int BOOT_OSC_LSB        = 0;
   localparam logic [2:0] BOOT_OSC_RST = 3'h0;
   localparam logic [31:0] RESET_VECTOR = 32'hBFC0_0000;
   // avalon request bundle
   typedef struct packed {
      logic [5:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } avmm_req_s;
   typedef enum {ST_POWERUP, ST_PRESET, ST_RELOAD, ST_OSC, ST_SYSDLY,
                 ST_RUN} seq_state_e;
endpackage

/* File: tb/tb_top.sv */
// self-checking bench for the reset source controller
`timescale 1ns/10ps
module tb_top;
   import rstc_pkg::*;
   // short power-up count keeps the run brief
   localparam int PWR_CYC = 20;
   logic        i_clk_sys;
   logic        i_rst_n;
   logic        ext_n;
   logic        wdt;
   logic        bor;
   logic        slp;
   logic        idl;
   logic        wake;
   logic        cfg_ld;
   avmm_req_s   avmm;
   logic [31:0] rdata;
   logic [31:0] vec;
   logic [31:0] cfg_w;
   logic [31:0] cfg_c;
   logic [31:0] q;
   logic [31:0] pc;
   logic [2:0]  osc;
   logic        wreq;
   logic        internal_system_reset;
   logic        core;
   logic        preset;
   logic        wake_rv;
   int          num_errors;
   int          n_compared;
   int          cyc;
   int          rst_cnt;
   int          wake_cnt;
   int          preset_cnt;
   int          base;
   int          wbase;

   reset_source_controller #(.POWERUP_CYCLES(PWR_CYC))
      reset_source_controller_inst (
      .i_clk_sys               (i_clk_sys),
      .i_rst_n                 (i_rst_n),
      .i_avmm                  (avmm),
      .o_avmm_readdata         (rdata),
      .o_avmm_waitrequest      (wreq),
      .i_ext_reset_pin_n       (ext_n),
      .i_watchdog_timeout      (wdt),
      .i_brownout              (bor),
      .i_wait_sleep            (slp),
      .i_wait_idle             (idl),
      .i_int_wake              (wake),
      .i_int_vector            (vec),
      .i_cfg_word              (cfg_w),
      .i_cfg_comp              (cfg_c),
      .i_cfg_load_sleep        (cfg_ld),
      .o_internal_system_reset (internal_system_reset),
      .o_core_reset            (core),
      .o_cfg_preset            (preset),
      .o_cfg_reload            (),
      .o_boot_osc_select       (osc),
      .o_restart_pc            (pc),
      .o_wake_to_reset_vector  (wake_rv)
   );

   // 40 MHz system clock
   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end

   // event counters and a hang guard well beyond the expected run
   always @(posedge i_clk_sys) begin
      cyc = cyc + 1;
      if (internal_system_reset === 1'b1) rst_cnt = rst_cnt + 1;
      if (wake_rv === 1'b1) wake_cnt = wake_cnt + 1;
      if (preset === 1'b1) preset_cnt = preset_cnt + 1;
      if (cyc == 30000) begin
         num_errors = num_errors + 1;
         close_out();
      end
   end

   task automatic close_out();
      $display("errors %0d compares %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask

   // one avalon access; entered at a rising edge, waits for waitrequest low
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      avmm.address <= a;
      avmm.read <= ~wr;
      avmm.write <= wr;
      avmm.writedata <= d;
      // waitrequest and read data taken at the same rising edge
      do begin
         @(posedge i_clk_sys);
      end while (wreq !== 1'b0);
      q = rdata;
      avmm.read <= 1'b0;
      avmm.write <= 1'b0;
      // one idle edge so the next call never retimes a strobe
      @(posedge i_clk_sys);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, exp);
   endtask

   // waits out a reset and checks the core release lag after system reset
   task automatic settle();
      int n;
      int m;
      n = 0;
      m = 0;
      while (internal_system_reset !== 1'b1 && n < 20) begin
         @(negedge i_clk_sys);
         n = n + 1;
      end
      while (internal_system_reset !== 1'b0 && n < 2000) begin
         @(negedge i_clk_sys);
         n = n + 1;
      end
      while (core !== 1'b0 && m < 50) begin
         @(negedge i_clk_sys);
         m = m + 1;
      end
      chk(m, SYSDLY_CYC);
      @(posedge i_clk_sys);
   endtask

   initial begin
      {num_errors, n_compared, cyc, rst_cnt, wake_cnt, preset_cnt} = '0;
      avmm = '0;
      {ext_n, wdt, bor, slp, idl, wake, cfg_ld} = 7'b100_0000;
      vec = 32'h9D00_0200;
      // boot clock code 3 also exercises the oscillator delays
      cfg_w = 32'h0000_1233;
      cfg_c = ~32'h0000_1233;
      i_rst_n = 1'b0;
      tick(6);
      i_rst_n <= 1'b1;
      settle();
      rd(OFS_CAUSE, 32'h0000_0003);
      chk(pc, RESET_VECTOR);
      chk({29'h0, osc}, {29'h0, cfg_w[2:0]});
      // companion registers: clear, set, invert, then reads
      wr(OFS_CAUSE_CLR, 32'hFFFF_FFFF);
      rd(OFS_CAUSE, 32'h0000_0000);
      wr(OFS_CAUSE_SET, 32'h0000_0241);
      wr(OFS_CAUSE_INV, 32'h0000_0201);
      rd(OFS_CAUSE, 32'h0000_0040);
      rd(OFS_CAUSE_SET, 32'h0000_0000);
      wr(6'h3C, 32'hFFFF_FFFF);
      rd(6'h3C, 32'h0000_0000);
      rd(OFS_CAUSE, 32'h0000_0040);
      wr(OFS_CAUSE_CLR, 32'h0000_02DF);
      // arming while locked must not reset
      base = rst_cnt;
      wr(OFS_SWR_SET, 32'h0000_0001);
      bus(1'b0, OFS_SWR, 32'h0000_0000);
      tick(8);
      chk(rst_cnt - base, 0);
      // unlocked arm, then the triggering read
      wr(OFS_UNLOCK, UNLOCK_KEY1);
      wr(OFS_UNLOCK, UNLOCK_KEY2);
      wr(OFS_SWR, 32'h0000_0001);
      bus(1'b0, OFS_SWR, 32'h0000_0000);
      @(negedge i_clk_sys);
      @(negedge i_clk_sys);
      chk({31'h0, internal_system_reset}, 32'h0000_0001);
      settle();
      chk(pc, RESET_VECTOR);
      rd(OFS_CAUSE, 32'h0000_0040);
      wr(OFS_CAUSE_CLR, 32'h0000_02DF);
      // a short pin glitch is filtered, a long one resets
      base = rst_cnt;
      ext_n <= 1'b0;
      tick(4);
      ext_n <= 1'b1;
      tick(16);
      chk(rst_cnt - base, 0);
      ext_n <= 1'b0;
      tick(12);
      ext_n <= 1'b1;
      settle();
      rd(OFS_CAUSE, 32'h0000_0080);
      wr(OFS_CAUSE_CLR, 32'h0000_02DF);
      // watchdog while running
      wdt <= 1'b1;
      tick(3);
      wdt <= 1'b0;
      settle();
      rd(OFS_CAUSE, 32'h0000_0010);
      wr(OFS_CAUSE_CLR, 32'h0000_02DF);
      // watchdog in sleep only wakes
      slp <= 1'b1;
      tick(1);
      slp <= 1'b0;
      rd(OFS_CAUSE, 32'h0000_0008);
      base = rst_cnt;
      wbase = wake_cnt;
      wdt <= 1'b1;
      tick(3);
      wdt <= 1'b0;
      tick(8);
      chk(rst_cnt - base, 0);
      chk(wake_cnt - wbase, 1);
      rd(OFS_CAUSE, 32'h0000_0018);
      wr(OFS_CAUSE_CLR, 32'h0000_02DF);
      // interrupt exit from idle takes the given vector
      idl <= 1'b1;
      tick(1);
      idl <= 1'b0;
      tick(1);
      wake <= 1'b1;
      tick(1);
      wake <= 1'b0;
      tick(3);
      chk(pc, vec);
      rd(OFS_CAUSE, 32'h0000_0004);
      wr(OFS_CAUSE_CLR, 32'h0000_02DF);
      // two causes in one reset both leave flags
      ext_n <= 1'b0;
      wdt <= 1'b1;
      tick(12);
      ext_n <= 1'b1;
      wdt <= 1'b0;
      settle();
      chk(pc, RESET_VECTOR);
      rd(OFS_CAUSE, 32'h0000_0090);
      wr(OFS_CAUSE_CLR, 32'h0000_02DF);
      // configuration pair mismatch during a sleep load
      cfg_c <= cfg_w;
      cfg_ld <= 1'b1;
      tick(1);
      cfg_ld <= 1'b0;
      tick(4);
      cfg_c <= ~cfg_w;
      settle();
      bus(1'b0, OFS_CAUSE, 32'h0000_0000);
      chk(q & 32'h0000_0200, 32'h0000_0200);
      // brown-out clears all but power-on
      wr(OFS_CAUSE_SET, 32'h0000_02DD);
      bor <= 1'b1;
      tick(4);
      bor <= 1'b0;
      settle();
      rd(OFS_CAUSE, 32'h0000_0003);
      chk(preset_cnt, 1);
      close_out();
   end
endmodule
